// ==== design/dws_map.svh ====
// register offsets, field positions, reset values and counts of the disc write sequencer
`ifndef DWS_MAP_SVH
`define DWS_MAP_SVH

// apb byte offsets
`define DWS_OFF_CMD      8'h00
`define DWS_OFF_DATA     8'h04
`define DWS_OFF_TRACK    8'h08
`define DWS_OFF_PROT     8'h0c
`define DWS_OFF_STATUS   8'h10

// command register bits (write-only pulses)
`define DWS_CMD_SET_CTL  0
`define DWS_CMD_CLR_CTL  1
`define DWS_CMD_CLR_FLG  2

// track register fields
`define DWS_TRK_DIR      15

// protect register fields
`define DWS_PROT_SWITCH  8

// status register bits
`define DWS_ST_BUSY      0
`define DWS_ST_GATE      1
`define DWS_ST_EOS       2
`define DWS_ST_ABORT     3
`define DWS_ST_RUN       4
`define DWS_ST_MATCH     5
`define DWS_ST_SRQ       6
`define DWS_ST_CTL       7

// word timing in bit pulses
`define DWS_DATA_BITS    5'h10
`define DWS_WORD_BITS    5'h11

// reset values
`define DWS_RST_EXAMINE  8'hff
`define DWS_RST_WORD     16'h0000

`endif

// ==== design/dws_pkg.sv ====
// types shared by the disc write sequencer
package dws_pkg;

  // signals driven toward the disc drive
  typedef struct packed {
    logic       write_gate;
    logic       write_data_line;
    logic [7:0] track_addr_bits;
  } dws_disc_out_type;

  // apb answer to the bus master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dws_apb_out_type;

endpackage

// ==== design/dws_top.sv ====
// disc write sequencer: apb registers, word serializer and sector control
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dws_map.svh"

// What this block does
// - first word loads on run start, later on word end
// - seventeenth rise sets stored, advances word count
// - word count wrap sets end-of-sector, blocks requests
// - word end after 64th word clears run
// - second sector pulse clears counters, sets flags
// - kept sector match restarts run each sector
// - sixteen bits low first then parity bit
// - track address drives head select
// - first bit on line before first pulse
// - falling pulse edge shifts register toward low end
// - parity cleared per word, toggled per one
// - sixteenth fall clears word phase, sends parity
// - next word loads during parity, phase set after
// - clear control drops match, run ends later
// - partial sector repeats unchanged input word
// - busy status is control or run
// - closed switch disables all track protection
// - protected when examined address bits all zero
// - abort cleared at start, set on faults
// - abort flag reported as status bit three
// - write gate needs run, write direction, no protect
// - word load raises request, bus answers strobe
// - not-ready fault also clears sector match
module dws_top #(
  parameter int WORDS_LOG2 = 6
) (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [7:0]             PADDR,
  input  wire logic [31:0]            PWDATA,
  output var  dws_pkg::dws_apb_out_type  APB_OUT,
  input  wire logic                   DISC_BIT_PULSE,
  input  wire logic                   SECTOR_PULSE,
  input  wire logic                   DRIVE_NOT_READY_N,
  input  wire logic                   LINE_VOLTAGE_OK_N,
  output var  dws_pkg::dws_disc_out_type DISC_OUT,
  output logic                        SERVICE_REQUEST
);
  import dws_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bit_meta_r;
  logic [1:0] sec_meta_r;
  logic [1:0] nry_meta_r;
  logic [1:0] acl_meta_r;
  logic       bit_sync_r;
  logic       sec_sync_r;
  logic       nry_sync_r;
  logic       acl_sync_r;
  logic       bit_prev_r;
  logic       sec_prev_r;

  // two flops per pin, then one more stage on the bit and sector pins for edge finding
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_meta_r <= 2'h0;
      sec_meta_r <= 2'h0;
      nry_meta_r <= 2'h3;
      acl_meta_r <= 2'h0;
      bit_prev_r <= 1'h0;
      sec_prev_r <= 1'h0;
    end else begin
      bit_meta_r <= {bit_meta_r[0], DISC_BIT_PULSE};
      sec_meta_r <= {sec_meta_r[0], SECTOR_PULSE};
      nry_meta_r <= {nry_meta_r[0], DRIVE_NOT_READY_N};
      acl_meta_r <= {acl_meta_r[0], LINE_VOLTAGE_OK_N};
      bit_prev_r <= bit_sync_r;
      sec_prev_r <= sec_sync_r;
    end
  end

  assign bit_sync_r = bit_meta_r[1];
  assign sec_sync_r = sec_meta_r[1];
  assign nry_sync_r = nry_meta_r[1];
  assign acl_sync_r = acl_meta_r[1];

  logic bit_rise;
  logic bit_fall;
  logic sec_rise;
  logic not_ready;
  logic low_line;

  // edge events and fault levels
  assign bit_rise  = bit_sync_r & ~bit_prev_r;
  assign bit_fall  = ~bit_sync_r & bit_prev_r;
  assign sec_rise  = sec_sync_r & ~sec_prev_r;
  assign not_ready = ~nry_sync_r;
  assign low_line  = acl_sync_r;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        wr_fire;
  logic        mapped;

  // offset decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `DWS_OFF_CMD) || (a == `DWS_OFF_DATA) || (a == `DWS_OFF_TRACK) ||
                (a == `DWS_OFF_PROT) || (a == `DWS_OFF_STATUS);
  endfunction

  assign mapped  = is_mapped(PADDR);
  assign wr_fire = PSEL & PENABLE & pready_r & PWRITE & mapped;

  logic        ctl_r;
  logic        dir_r;
  logic [7:0]  track_r;
  logic [7:0]  examine_r;
  logic        switch_closed_r;
  logic [15:0] input_word_r;
  logic        srq_r;
  logic        run_r;
  logic        match_r;
  logic        eos_r;
  logic        abort_r;
  logic        gate_r;

  logic set_ctl;
  logic clr_ctl;
  logic clr_flg;
  logic out_strobe;

  // command pulses taken at the access edge
  assign set_ctl    = wr_fire && PADDR == `DWS_OFF_CMD && PWDATA[`DWS_CMD_SET_CTL];
  assign clr_ctl    = wr_fire && PADDR == `DWS_OFF_CMD && PWDATA[`DWS_CMD_CLR_CTL];
  assign clr_flg    = wr_fire && PADDR == `DWS_OFF_CMD && PWDATA[`DWS_CMD_CLR_FLG];
  assign out_strobe = wr_fire && PADDR == `DWS_OFF_DATA;

  logic [31:0] status_word;

  // status word assembly
  always_comb begin
    status_word                 = 32'h0000_0000;
    status_word[`DWS_ST_BUSY]   = ctl_r | run_r;
    status_word[`DWS_ST_GATE]   = gate_r;
    status_word[`DWS_ST_EOS]    = eos_r;
    status_word[`DWS_ST_ABORT]  = abort_r;
    status_word[`DWS_ST_RUN]    = run_r;
    status_word[`DWS_ST_MATCH]  = match_r;
    status_word[`DWS_ST_SRQ]    = srq_r;
    status_word[`DWS_ST_CTL]    = ctl_r;
  end

  // one wait-free access cycle, read data captured in setup
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_r  <= 1'h0;
      pslverr_r <= 1'h0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= PSEL & ~PENABLE;
      pslverr_r <= PSEL & ~PENABLE & ~mapped;
      if (PSEL & ~PENABLE & ~PWRITE) begin
        unique case (PADDR)
          `DWS_OFF_DATA:   prdata_r <= {16'h0000, input_word_r};
          `DWS_OFF_TRACK:  prdata_r <= {16'h0000, dir_r, 7'h00, track_r};
          `DWS_OFF_PROT:   prdata_r <= {23'h000000, switch_closed_r, examine_r};
          `DWS_OFF_STATUS: prdata_r <= status_word;
          default:         prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb begin
    APB_OUT.pready  = pready_r;
    APB_OUT.pslverr = pslverr_r;
    APB_OUT.prdata  = prdata_r;
  end

  // configuration registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      track_r         <= 8'h00;
      dir_r           <= 1'h0;
      examine_r       <= `DWS_RST_EXAMINE;
      switch_closed_r <= 1'h1;
      input_word_r    <= `DWS_RST_WORD;
    end else begin
      if (wr_fire && PADDR == `DWS_OFF_TRACK) begin
        track_r <= PWDATA[7:0];
        dir_r   <= PWDATA[`DWS_TRK_DIR];
      end
      if (wr_fire && PADDR == `DWS_OFF_PROT) begin
        examine_r       <= PWDATA[7:0];
        switch_closed_r <= PWDATA[`DWS_PROT_SWITCH];
      end
      if (out_strobe) begin
        input_word_r <= PWDATA[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sector control
  // ----------------------------------------------------------------
  logic sec_second_r;
  logic sec_first_evt;
  logic sec_second_evt;
  logic writing;

  assign sec_first_evt  = sec_rise & ~sec_second_r;
  assign sec_second_evt = sec_rise & sec_second_r;
  assign writing        = (ctl_r | run_r) & dir_r;

  // pulse pair phase within each sector
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sec_second_r <= 1'h0;
    end else if (sec_rise) begin
      sec_second_r <= ~sec_second_r;
    end
  end

  // control bit, set and cleared from the bus
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_r <= 1'h0;
    end else if (set_ctl) begin
      ctl_r <= 1'h1;
    end else if (clr_ctl) begin
      ctl_r <= 1'h0;
    end
  end

  // sector match follows the control bit and the drive readiness
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      match_r <= 1'h0;
    end else if (~ctl_r | clr_ctl) begin
      match_r <= 1'h0;
    end else if (writing & not_ready) begin
      match_r <= 1'h0;
    end else if (sec_first_evt & dir_r) begin
      match_r <= 1'h1;
    end
  end

  // abort-store flag
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      abort_r <= 1'h0;
    end else if (writing & (not_ready | low_line)) begin
      abort_r <= 1'h1;
    end else if (set_ctl) begin
      abort_r <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // word and bit sequencing
  // ----------------------------------------------------------------
  logic [4:0]            bit_cnt_r;
  logic [WORDS_LOG2-1:0] word_cnt_r;
  logic                  phase_r;
  logic                  stored_r;
  logic [15:0]           shift_r;
  logic                  parity_r;
  logic                  run_first_word;
  logic                  end_word_write_n;
  logic                  load_word;
  logic                  rise17;
  logic                  fall16;
  logic                  fall17;
  logic                  last_word;

  assign run_first_word   = sec_second_evt & match_r;
  assign rise17           = run_r & bit_rise & (bit_cnt_r == `DWS_WORD_BITS - 5'h01);
  assign fall16           = run_r & bit_fall & (bit_cnt_r == `DWS_DATA_BITS);
  assign fall17           = run_r & bit_fall & (bit_cnt_r == `DWS_WORD_BITS);
  assign last_word        = (word_cnt_r == '1);
  // no load and no request once the last word of the sector is under way
  assign end_word_write_n = ~(fall16 & ~last_word & ~eos_r);
  assign load_word        = run_first_word | ~end_word_write_n;

  // run flag, set per sector and cleared after the last word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_r <= 1'h0;
    end else if (run_first_word) begin
      run_r <= 1'h1;
    end else if (fall17 & eos_r) begin
      run_r <= 1'h0;
    end
  end

  // bit counter counts rising pulse edges within a word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_cnt_r <= 5'h00;
    end else if (sec_second_evt | fall17) begin
      bit_cnt_r <= 5'h00;
    end else if (run_r & bit_rise) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // word counter and end-of-sector flag
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      word_cnt_r <= '0;
      eos_r      <= 1'h0;
    end else if (sec_second_evt) begin
      word_cnt_r <= '0;
      eos_r      <= 1'h0;
    end else if (rise17) begin
      word_cnt_r <= word_cnt_r + 1'b1;
      if (word_cnt_r == '1) begin
        eos_r <= 1'h1;
      end
    end
  end

  // word-phase and word-stored flags
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_r  <= 1'h1;
      stored_r <= 1'h1;
    end else if (sec_second_evt) begin
      phase_r  <= 1'h1;
      stored_r <= 1'h1;
    end else begin
      if (fall16) begin
        phase_r  <= 1'h0;
        stored_r <= 1'h0;
      end else if (fall17) begin
        phase_r <= 1'h1;
      end
      if (rise17) begin
        stored_r <= 1'h1;
      end
    end
  end

  // shift register and running parity; parity holds through the parity bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift_r  <= 16'h0000;
      parity_r <= 1'h0;
    end else begin
      if (load_word) begin
        shift_r <= input_word_r;
      end else if (run_r & bit_fall & phase_r) begin
        shift_r <= {1'b0, shift_r[15:1]};
      end
      if (run_first_word | fall17) begin
        parity_r <= 1'h0;
      end else if (run_r & bit_fall & phase_r) begin
        parity_r <= parity_r ^ shift_r[0];
      end
    end
  end

  // service request raised by each load, blocked at end of sector
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      srq_r <= 1'h0;
    end else if (load_word) begin
      srq_r <= 1'h1;
    end else if (clr_flg) begin
      srq_r <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // disc outputs
  // ----------------------------------------------------------------
  logic protected_trk;
  logic data_bit;
  logic dwl_r;

  assign protected_trk = ~switch_closed_r & ((track_r & examine_r) == 8'h00);
  assign data_bit      = phase_r ? shift_r[0] : ~parity_r;

  // registered drive of gate and data; head select comes straight from the track register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gate_r <= 1'h0;
      dwl_r  <= 1'h0;
    end else begin
      gate_r <= run_r & dir_r & ~protected_trk;
      dwl_r  <= data_bit;
    end
  end

  always_comb begin
    DISC_OUT.write_gate      = gate_r;
    DISC_OUT.write_data_line = dwl_r;
    DISC_OUT.track_addr_bits = track_r;
  end

  assign SERVICE_REQUEST = srq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  store_count_a: assert property (@(posedge CLK) disable iff (RST)
    rise17 & ~sec_second_evt |=> stored_r && word_cnt_r == $past(word_cnt_r) + 1'b1)
    else $error("word count or stored flag not updated on seventeenth rise");

  eos_block_a: assert property (@(posedge CLK) disable iff (RST)
    eos_r & ~sec_second_evt |=> ~$rose(srq_r))
    else $error("service request raised at end of sector");

  last_req_a: assert property (@(posedge CLK) disable iff (RST)
    fall16 && word_cnt_r == '1 |=> !$rose(srq_r))
    else $error("service request raised after last word of sector");

  run_stop_a: assert property (@(posedge CLK) disable iff (RST)
    fall17 & eos_r & ~run_first_word |=> ~run_r ##1 ~gate_r)
    else $error("run or gate still up after last word");

  sector_clear_a: assert property (@(posedge CLK) disable iff (RST)
    sec_second_evt |=> ~eos_r && word_cnt_r == '0 && bit_cnt_r == 5'h00 && phase_r && stored_r)
    else $error("second sector pulse did not clear counters");

  parity_out_a: assert property (@(posedge CLK) disable iff (RST)
    fall16 |=> ~phase_r ##1 dwl_r == ~parity_r)
    else $error("parity bit not on data line");

  phase_back_a: assert property (@(posedge CLK) disable iff (RST)
    fall17 & ~sec_second_evt |=> phase_r && bit_cnt_r == 5'h00)
    else $error("word phase not restored after parity");

  busy_status_a: assert property (@(posedge CLK) disable iff (RST)
    status_word[`DWS_ST_BUSY] == (ctl_r | run_r))
    else $error("busy status mismatch");

  gate_cause_a: assert property (@(posedge CLK) disable iff (RST)
    gate_r |-> $past(run_r) && $past(dir_r) && !$past(protected_trk))
    else $error("write gate without cause");

  abort_set_a: assert property (@(posedge CLK) disable iff (RST)
    writing & not_ready |=> abort_r && ~match_r)
    else $error("fault did not set abort or clear match");

endmodule
`default_nettype wire

// ==== sim/dws_disc_model.sv ====
// behavioural disc drive: sector pulse pairs, bit pulse trains, recorded bits
`timescale 1ns/1ps
`default_nettype none
module dws_disc_model #(
  parameter int WORDS = 4
) (
  input  wire logic                      clk,
  input  wire dws_pkg::dws_disc_out_type disc_out,
  output logic                           bit_pulse,
  output logic                           sector_pulse
);
  import dws_pkg::*;
  logic bits_q[$];
  logic gate_seen;

  // lines stand still between sectors
  initial begin
    bit_pulse = 1'b0;
    sector_pulse = 1'b0;
    gate_seen = 1'b0;
  end

  // one sector: pulse pair, then a bit train only if the write gate rises within 40 clocks
  task automatic run_sector();
    int n;
    bits_q.delete();
    #37;
    repeat (2) begin
      sector_pulse = 1'b1;
      #400;
      sector_pulse = 1'b0;
      #400;
    end
    n = 0;
    while (disc_out.write_gate !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    gate_seen = disc_out.write_gate;
    if (gate_seen === 1'b1) begin
      #437;
      for (int i = 0; i < WORDS * 17; i++) begin
        bits_q.push_back(disc_out.write_data_line);
        bit_pulse = 1'b1;
        #400;
        bit_pulse = 1'b0;
        #400;
      end
    end
    #1600;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_disc_write_sequencer.sv ====
// self-checking bench of the disc write sequencer over apb and a drive model
`timescale 1ns/1ps
`default_nettype none
`include "dws_map.svh"
module tb_disc_write_sequencer;
  import dws_pkg::*;
  localparam int WORDS_LOG2 = 2;
  localparam int WORDS = 1 << WORDS_LOG2;
  logic             clk;
  logic             rst;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic             not_ready_n;
  logic             line_ok_n;
  logic             bit_pulse;
  logic             sector_pulse;
  logic             service_request;
  dws_apb_out_type  apb_out;
  dws_disc_out_type disc_out;
  logic [31:0]      rd;
  logic             err;
  logic [15:0]      words [6];
  logic [8:0]       prot_t [6];
  logic [15:0]      track_t [6];
  logic             gate_t [6];
  int               fails;
  int               num_checks;

  dws_top #(.WORDS_LOG2(WORDS_LOG2)) dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .APB_OUT(apb_out), .DISC_BIT_PULSE(bit_pulse),
    .SECTOR_PULSE(sector_pulse), .DRIVE_NOT_READY_N(not_ready_n),
    .LINE_VOLTAGE_OK_N(line_ok_n), .DISC_OUT(disc_out), .SERVICE_REQUEST(service_request));

  dws_disc_model #(.WORDS(WORDS)) disc (
    .clk(clk), .disc_out(disc_out), .bit_pulse(bit_pulse), .sector_pulse(sector_pulse));

  // system clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (apb_out.pready !== 1'b1);
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_bit(input string what, input int pos, input logic exp);
    apb(1'b0, `DWS_OFF_STATUS, 32'h0);
    chk(what, {31'h0, exp}, {31'h0, rd[pos]});
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask

  // answer each word request with a flag clear and the next word
  task automatic feed(input int first, input int last);
    for (int i = first; i <= last; i++) begin
      while (service_request !== 1'b1) @(posedge clk);
      apb(1'b1, `DWS_OFF_CMD, 32'h4);
      apb(1'b1, `DWS_OFF_DATA, {16'h0, words[i]});
    end
  endtask

  // recorded bits: sixteen data bits low first, then odd parity
  task automatic check_bits(input logic [15:0] ws [WORDS]);
    logic [16:0] got;
    chk("bit count", WORDS * 17, disc.bits_q.size());
    for (int k = 0; k < WORDS; k++) begin
      for (int b = 0; b < 17; b++) got[b] = disc.bits_q[k * 17 + b];
      chk("word on disc", {15'h0, ~^ws[k], ws[k]}, {15'h0, got});
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #5000000;
    fails++;
    print_verdict();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    not_ready_n = 1'b1;
    line_ok_n = 1'b0;
    fails = 0;
    num_checks = 0;
    words = '{16'h8001, 16'h0000, 16'hffff, 16'h1234, 16'ha5c3, 16'h7e01};
    prot_t = '{9'h0ff, 9'h0fe, 9'h0ff, 9'h1ff, 9'h1ff, 9'h000};
    track_t = '{16'h8000, 16'h8001, 16'h8001, 16'h8000, 16'h0001, 16'h80ff};
    gate_t = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    do_reset();
    apb(1'b0, `DWS_OFF_STATUS, 32'h0);
    chk("status after reset", 32'h0, rd);
    apb(1'b0, `DWS_OFF_PROT, 32'h0);
    chk("protect after reset", 32'h1ff, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    // full sector then a partial one
    apb(1'b1, `DWS_OFF_TRACK, 32'h8005);
    apb(1'b1, `DWS_OFF_DATA, {16'h0, words[0]});
    apb(1'b1, `DWS_OFF_CMD, 32'h1);
    chk_bit("busy from control", `DWS_ST_BUSY, 1'b1);
    chk("track to heads", 32'h5, {24'h0, disc_out.track_addr_bits});
    fork
      disc.run_sector();
      feed(1, 4);
    join
    check_bits('{words[0], words[1], words[2], words[3]});
    chk("gate after last word", 32'h0, {31'h0, disc_out.write_gate});
    chk("request at end", 32'h0, {31'h0, service_request});
    chk_bit("run at end", `DWS_ST_RUN, 1'b0);
    chk_bit("end of sector", `DWS_ST_EOS, 1'b1);
    chk_bit("match kept", `DWS_ST_MATCH, 1'b1);
    fork
      disc.run_sector();
      begin
        feed(5, 5);
        apb(1'b1, `DWS_OFF_CMD, 32'h2);
        chk_bit("match after clear", `DWS_ST_MATCH, 1'b0);
        chk_bit("busy from run", `DWS_ST_BUSY, 1'b1);
      end
    join
    check_bits('{words[4], words[5], words[5], words[5]});
    disc.run_sector();
    chk("gate after finish", 32'h0, {31'h0, disc.gate_seen});
    chk_bit("idle", `DWS_ST_BUSY, 1'b0);
    // protection table
    for (int k = 0; k < 6; k++) begin
      do_reset();
      apb(1'b1, `DWS_OFF_PROT, {23'h0, prot_t[k]});
      apb(1'b1, `DWS_OFF_TRACK, {16'h0, track_t[k]});
      apb(1'b1, `DWS_OFF_CMD, 32'h1);
      disc.run_sector();
      chk("protect gate", {31'h0, gate_t[k]}, {31'h0, disc.gate_seen});
    end
    // drive faults during a write
    do_reset();
    apb(1'b1, `DWS_OFF_TRACK, 32'h8005);
    apb(1'b1, `DWS_OFF_CMD, 32'h1);
    fork
      disc.run_sector();
      begin
        wait (disc_out.write_gate === 1'b1);
        @(posedge clk);
        not_ready_n <= 1'b0;
        repeat (5) @(posedge clk);
        not_ready_n <= 1'b1;
        chk_bit("abort on not ready", `DWS_ST_ABORT, 1'b1);
        chk_bit("match on not ready", `DWS_ST_MATCH, 1'b0);
      end
    join
    chk_bit("run after fault", `DWS_ST_RUN, 1'b0);
    apb(1'b1, `DWS_OFF_CMD, 32'h1);
    chk_bit("abort on start", `DWS_ST_ABORT, 1'b0);
    line_ok_n <= 1'b1;
    repeat (5) @(posedge clk);
    line_ok_n <= 1'b0;
    chk_bit("abort on low line", `DWS_ST_ABORT, 1'b1);
    chk_bit("control on low line", `DWS_ST_CTL, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
